// file: verilog/btt_termination.sv
`timescale 1ns/100ps
module btt_termination #(
    parameter int RETRY_MAX = btt_pkg::RETRY_LIMIT
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic [btt_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [btt_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // initiator bus: delayed request attempt
    input wire logic ini_req,
    input wire logic ini_read,
    input wire logic ini_match,
    input wire logic ini_multi,
    input wire logic ini_more,
    input wire logic ini_prefetch,
    input wire logic ini_special,
    input wire logic queue_full,
    // initiator bus: termination answer
    output logic ini_resp,
    output logic ini_claim,
    output logic ini_trdy,
    output logic ini_stop,
    // target bus pins
    output logic frame_n_o,
    output logic frame_n_oe,
    output logic irdy_n_o,
    output logic irdy_n_oe,
    input wire logic trdy_n,
    input wire logic stop_n,
    input wire logic target_claim_n
);
    import btt_pkg::*;

    logic enable;
    logic [15:0] timeout;
    logic rx_mabort, rx_tabort, sig_tabort;
    logic [ATT_W-1:0] attempts;
    btt_dt_type dt;
    btt_out_type dt_out;
    logic dt_read, dt_prefetch, dt_special, dt_burst;
    logic [15:0] idle_cnt;
    btt_tgt_type ts;
    logic [2:0] wait_cnt;
    logic claimed, xfered;
    logic tgt_done;
    btt_out_type tgt_out;
    logic aw_held, w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_go, clr_tabort_hit;
    logic next_claim, next_trdy, next_stop, next_sig;
    logic [ATT_W-1:0] next_attempts;
    logic [31:0] ctrl_merged, tmo_merged;

    // byte-lane merge for 32-bit registers
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // write address and data are taken in either order
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign wr_go = aw_held && w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr == REG_CTRL || aw_addr == REG_TIMEOUT ||
                                aw_addr == REG_STATUS) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            unique case (s_axi_araddr)
                REG_CTRL: s_axi_rdata <= {31'h0, enable};
                REG_TIMEOUT: s_axi_rdata <= {16'h0, timeout};
                REG_STATUS: s_axi_rdata <= {29'h0, sig_tabort, rx_tabort, rx_mabort};
                REG_ATTEMPT: s_axi_rdata <= {7'h0, attempts};
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // control registers; enable gates starts at the target bus
    assign ctrl_merged = merge({31'h0, enable}, w_data, w_strb);
    assign tmo_merged = merge({16'h0, timeout}, w_data, w_strb);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable <= CTRL_RESET;
            timeout <= TIMEOUT_RESET;
        end else if (wr_go && aw_addr == REG_CTRL) begin
            enable <= ctrl_merged[CTRL_ENABLE];
        end else if (wr_go && aw_addr == REG_TIMEOUT) begin
            timeout <= tmo_merged[15:0];
        end
    end

    // sticky status, write one to clear; a new event wins over the clear
    assign clr_tabort_hit = wr_go && aw_addr == REG_STATUS && w_strb[0];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_mabort <= 1'b0;
            rx_tabort <= 1'b0;
            sig_tabort <= 1'b0;
        end else begin
            if (tgt_done && tgt_out == OUT_MABORT && !dt_special) begin
                rx_mabort <= 1'b1;
            end else if (clr_tabort_hit && w_data[ST_RX_MABORT]) begin
                rx_mabort <= 1'b0;
            end
            if (tgt_done && tgt_out == OUT_TABORT) begin
                rx_tabort <= 1'b1;
            end else if (clr_tabort_hit && w_data[ST_RX_TABORT]) begin
                rx_tabort <= 1'b0;
            end
            if (next_sig) begin
                sig_tabort <= 1'b1;
            end else if (clr_tabort_hit && w_data[ST_SIG_TABORT]) begin
                sig_tabort <= 1'b0;
            end
        end
    end

    // termination answer to a repeat of the delayed request
    always_comb begin
        next_claim = 1'b1;
        next_trdy = 1'b0;
        next_stop = 1'b1;
        next_sig = 1'b0;
        if (ini_req && dt == DT_DONE && ini_match) begin
            unique case (dt_out)
                OUT_MABORT: begin
                    if (dt_special) begin
                        next_trdy = 1'b1;
                        next_stop = ini_multi;
                    end else begin
                        next_claim = 1'b0;
                        next_stop = 1'b0;
                    end
                end
                OUT_TABORT: begin
                    next_claim = 1'b0;
                    next_sig = 1'b1;
                end
                default: begin
                    next_trdy = 1'b1;
                    if (!dt_read) begin
                        next_stop = ini_multi;
                    end else if (dt_prefetch) begin
                        next_stop = ini_more;
                    end else begin
                        next_stop = 1'b1;
                    end
                end
            endcase
        end
        // anything else, queue busy, full or slow, is a retry
    end

    // answer is registered and shows for one cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ini_resp <= 1'b0;
            ini_claim <= 1'b0;
            ini_trdy <= 1'b0;
            ini_stop <= 1'b0;
        end else begin
            ini_resp <= ini_req;
            ini_claim <= ini_req && next_claim;
            ini_trdy <= ini_req && next_trdy;
            ini_stop <= ini_req && next_stop;
        end
    end

    // attempt count after a target retry; the limit turns into an abort
    assign next_attempts = attempts + ATT_W'(1);

    // delayed transaction slot: one entry, so a second request finds it full
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dt <= DT_EMPTY;
            dt_out <= OUT_DATA;
            dt_read <= 1'b0;
            dt_prefetch <= 1'b0;
            dt_special <= 1'b0;
            dt_burst <= 1'b0;
            attempts <= '0;
            idle_cnt <= '0;
        end else begin
            unique case (dt)
                DT_EMPTY: begin
                    if (ini_req && !queue_full) begin
                        dt <= DT_QUEUED;
                        dt_read <= ini_read;
                        dt_prefetch <= ini_read && ini_prefetch;
                        dt_special <= ini_special;
                        dt_burst <= ini_read && ini_prefetch && ini_multi;
                        attempts <= '0;
                    end
                end
                DT_QUEUED: begin
                    idle_cnt <= '0;
                    if (tgt_done) begin
                        if (tgt_out == OUT_RETRY) begin
                            attempts <= next_attempts;
                            if (next_attempts >= ATT_W'(RETRY_MAX)) begin
                                dt <= DT_DONE;
                                dt_out <= OUT_TABORT;
                            end
                            // otherwise stay queued and try again
                        end else begin
                            dt <= DT_DONE;
                            dt_out <= tgt_out;
                        end
                    end
                end
                DT_DONE: begin
                    idle_cnt <= idle_cnt + 16'h1;
                    if (ini_req && ini_match) begin
                        dt <= DT_EMPTY;
                    end else if (idle_cnt >= timeout) begin
                        dt <= DT_EMPTY;
                    end
                end
                default: dt <= DT_EMPTY;
            endcase
        end
    end

    // target bus sequencer: address phase, data phases, orderly release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ts <= T_IDLE;
            frame_n_o <= 1'b1;
            irdy_n_o <= 1'b1;
            frame_n_oe <= 1'b0;
            irdy_n_oe <= 1'b0;
            wait_cnt <= '0;
            claimed <= 1'b0;
            xfered <= 1'b0;
            tgt_done <= 1'b0;
            tgt_out <= OUT_DATA;
        end else begin
            tgt_done <= 1'b0;
            unique case (ts)
                T_IDLE: begin
                    if (dt == DT_QUEUED && enable && !tgt_done) begin
                        ts <= T_ADDR;
                        frame_n_o <= 1'b0;
                        frame_n_oe <= 1'b1;
                        irdy_n_oe <= 1'b1;
                        wait_cnt <= 3'h1;
                        claimed <= 1'b0;
                        xfered <= 1'b0;
                    end
                end
                T_ADDR: begin
                    ts <= T_DATA;
                    irdy_n_o <= 1'b0;
                    frame_n_o <= !dt_burst;
                    wait_cnt <= wait_cnt + 3'h1;
                end
                T_DATA: begin
                    if (!target_claim_n) begin
                        claimed <= 1'b1;
                    end
                    if (wait_cnt != CLAIM_WAIT) begin
                        wait_cnt <= wait_cnt + 3'h1;
                    end
                    if (!stop_n) begin
                        // target ends it; frame must go before irdy
                        ts <= frame_n_o ? T_END : T_DRAIN;
                        frame_n_o <= 1'b1;
                        irdy_n_o <= frame_n_o;
                        tgt_done <= 1'b1;
                        if (!target_claim_n && !trdy_n) begin
                            tgt_out <= OUT_DATA;
                        end else if (!target_claim_n) begin
                            tgt_out <= xfered ? OUT_DATA : OUT_RETRY;
                        end else if (claimed) begin
                            tgt_out <= OUT_TABORT;
                        end else begin
                            tgt_out <= OUT_MABORT;
                        end
                    end else if (!trdy_n && !target_claim_n) begin
                        xfered <= 1'b1;
                        if (frame_n_o) begin
                            ts <= T_END;
                            irdy_n_o <= 1'b1;
                            tgt_done <= 1'b1;
                            tgt_out <= OUT_DATA;
                        end else begin
                            frame_n_o <= 1'b1;
                        end
                    end else if (!claimed && target_claim_n && wait_cnt == CLAIM_WAIT) begin
                        tgt_done <= 1'b1;
                        tgt_out <= OUT_MABORT;
                        if (!frame_n_o) begin
                            frame_n_o <= 1'b1;
                            ts <= T_DRAIN;
                        end else begin
                            irdy_n_o <= 1'b1;
                            ts <= T_END;
                        end
                    end
                end
                T_DRAIN: begin
                    irdy_n_o <= 1'b1;
                    ts <= T_END;
                end
                T_END: begin
                    // one clock of driven high before letting go of the pins
                    frame_n_oe <= 1'b0;
                    irdy_n_oe <= 1'b0;
                    ts <= T_IDLE;
                end
                default: ts <= T_IDLE;
            endcase
        end
    end
endmodule

// file: verilog/btt_pkg.sv
package btt_pkg;
    // register byte offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_TIMEOUT = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_ATTEMPT = 4'hc;
    localparam int ADDR_W = 4;
    // field positions
    localparam int CTRL_ENABLE = 0;
    localparam int ST_RX_MABORT = 0;
    localparam int ST_RX_TABORT = 1;
    localparam int ST_SIG_TABORT = 2;
    // reset values
    localparam logic [15:0] TIMEOUT_RESET = 16'h8000;
    localparam logic CTRL_RESET = 1'b1;
    // clocks from frame asserted to the last allowed claim
    localparam logic [2:0] CLAIM_WAIT = 3'h5;
    // attempts at the target before giving up
    localparam int RETRY_LIMIT = 1 << 24;
    localparam int ATT_W = 25;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // delayed transaction slot
    typedef enum logic [1:0] {
        DT_EMPTY,
        DT_QUEUED,
        DT_DONE
    } btt_dt_type;
    // outcome seen at the target bus
    typedef enum logic [1:0] {
        OUT_DATA,
        OUT_RETRY,
        OUT_MABORT,
        OUT_TABORT
    } btt_out_type;
    // target bus initiator sequencer
    typedef enum logic [2:0] {
        T_IDLE,
        T_ADDR,
        T_DATA,
        T_DRAIN,
        T_END
    } btt_tgt_type;
endpackage

// file: testbench/btt_target_model.sv
`timescale 1ns/100ps
// far-bus target; a released line floats high on the bus pull-ups
module btt_target_model (
    // clock and behaviour: 0 data, 1 retry, 2 target abort, 3 no claim
    input wire logic aclk,
    input wire logic [1:0] mode,
    input wire logic [1:0] dly,
    // bus pins
    input wire logic frame_n_o,
    input wire logic frame_n_oe,
    input wire logic irdy_n_o,
    output logic trdy_n,
    output logic stop_n,
    output logic target_claim_n
);
    logic busy = 1'h0;
    logic [3:0] cnt = 4'h0;

    // pins released until the first frame
    initial begin
        trdy_n = 1'h1;
        stop_n = 1'h1;
        target_claim_n = 1'h1;
    end

    // claim after dly clocks, answer a clock later, let go once irdy is released
    always @(posedge aclk) begin
        if (!busy) begin
            busy <= frame_n_oe && !frame_n_o && mode != 2'h3;
            cnt <= 4'h0;
        end else begin
            cnt <= cnt + 4'h1;
            if (cnt == {2'h0, dly}) target_claim_n <= 1'h0;
            if (cnt == {2'h0, dly} + 4'h1) begin
                trdy_n <= mode != 2'h0;
                stop_n <= mode == 2'h0;
                target_claim_n <= mode == 2'h2;
            end
            // a late release would hold the bus; pull-ups restore the idle level
            if ((cnt > {2'h0, dly} + 4'h1 && irdy_n_o) || !frame_n_oe) begin
                trdy_n <= 1'h1;
                stop_n <= 1'h1;
                target_claim_n <= 1'h1;
                busy <= 1'h0;
            end
        end
    end
endmodule

// file: testbench/btt_termination_chk.sv
`timescale 1ns/100ps
module btt_termination_chk (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // initiator side
    input wire logic ini_req,
    input wire logic ini_read,
    input wire logic ini_multi,
    input wire logic ini_more,
    input wire logic ini_prefetch,
    input wire logic ini_resp,
    input wire logic ini_claim,
    input wire logic ini_trdy,
    input wire logic ini_stop,
    // target bus
    input wire logic frame_n_o,
    input wire logic frame_n_oe,
    input wire logic irdy_n_o,
    input wire logic irdy_n_oe,
    input wire logic trdy_n,
    input wire logic stop_n,
    input wire logic target_claim_n
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // each attempt is answered one clock later
    property p_answer;
        ini_req |=> ini_resp;
    endproperty
    a_answer: assert property (p_answer) else $error("attempt not answered");

    // data answer always carries the claim
    property p_data_claim;
        ini_resp && ini_trdy |-> ini_claim;
    endproperty
    a_data_claim: assert property (p_data_claim) else $error("data without claim");

    // unclaimed answers move no data
    property p_abort_shape;
        ini_resp && !ini_claim |-> !ini_trdy;
    endproperty
    a_abort_shape: assert property (p_abort_shape) else $error("data without claim");

    // write data answer disconnects only for multi-phase requests
    property p_write_disc;
        ini_resp && ini_trdy && !$past(ini_read) |-> ini_stop == $past(ini_multi);
    endproperty
    a_write_disc: assert property (p_write_disc) else $error("write disconnect wrong");

    // read data answer: prefetch follows the more-data request, else disconnect
    property p_read_disc;
        ini_resp && ini_trdy && $past(ini_read) |-> ini_stop == ($past(ini_prefetch) ? $past(ini_more) : 1'h1);
    endproperty
    a_read_disc: assert property (p_read_disc) else $error("read disconnect wrong");

    // unclaimed frame gives up after the claim window
    property p_mabort;
        ($fell(frame_n_o) && frame_n_oe) ##1 (target_claim_n && !irdy_n_o)[*4] |=> ##[0:1] irdy_n_o;
    endproperty
    a_mabort: assert property (p_mabort) else $error("no master abort");

    // irdy is never let go before frame
    property p_irdy_after_frame;
        $rose(irdy_n_o) && irdy_n_oe |-> $past(frame_n_o);
    endproperty
    a_irdy_after_frame: assert property (p_irdy_after_frame) else $error("irdy before frame");

    // frame released only with irdy asserted
    property p_frame_irdy;
        $rose(frame_n_o) && frame_n_oe |-> !irdy_n_o && irdy_n_oe;
    endproperty
    a_frame_irdy: assert property (p_frame_irdy) else $error("frame released without irdy");

    // drivers stay on for a clock after irdy release
    property p_oe_hold;
        $fell(irdy_n_oe) |-> $past(irdy_n_o);
    endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("irdy driver dropped early");

    // any target termination in the last phase ends the transfer
    property p_end;
        irdy_n_oe && !irdy_n_o && frame_n_o && (!trdy_n || !stop_n) |=> irdy_n_o;
    endproperty
    a_end: assert property (p_end) else $error("termination ignored");
endmodule

bind btt_termination btt_termination_chk i_btt_termination_chk (.*);

// file: testbench/btt_termination_tb.sv
`timescale 1ns/100ps
module btt_termination_tb;
    import btt_pkg::*;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic ini_req = 1'h0, ini_read = 1'h0, ini_match = 1'h0, ini_multi = 1'h0, ini_more = 1'h0;
    logic ini_prefetch = 1'h0, ini_special = 1'h0, queue_full = 1'h0;
    logic ini_resp, ini_claim, ini_trdy, ini_stop;
    logic frame_n_o, frame_n_oe, irdy_n_o, irdy_n_oe, trdy_n, stop_n, target_claim_n;
    logic [1:0] mode = 2'h0, dly = 2'h0;
    logic [4:0] q = 5'h0;
    logic [2:0] r;
    int fails = 0, compares = 0;

    // a short retry limit keeps the give-up case quick
    btt_termination #(.RETRY_MAX(4)) i_btt_termination (.*);
    btt_target_model i_btt_target_model (.*);

    // clock
    always #4 aclk = ~aclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // register write; address and data held until each is taken
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        tb = 1'h0;
        while (!tb) begin
            #1;
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            rr = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'h0;
            if (tw) s_axi_wvalid <= 1'h0;
            if (tb) s_axi_bready <= 1'h0;
        end
    endtask

    // register read compared against an expected word
    task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
        logic ta, tr;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        tr = 1'h0;
        while (!tr) begin
            #1;
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid;
            rv = s_axi_rdata;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'h0;
            if (tr) s_axi_rready <= 1'h0;
        end
        chk(rv, exp);
    endtask

    // one initiator attempt; r holds claim, trdy, stop of the answer
    task automatic att(input logic m);
        @(posedge aclk);
        ini_req <= 1'h1;
        ini_match <= m;
        {ini_read, ini_multi, ini_more, ini_prefetch, ini_special} <= q;
        @(posedge aclk);
        ini_req <= 1'h0;
        #1;
        chk(32'(ini_resp), 32'h1);
        r = {ini_claim, ini_trdy, ini_stop};
    endtask

    // queue a request, then repeat it until the answer is no longer a retry
    task automatic txn(input logic [4:0] qq, input logic [2:0] exp);
        int n;
        q = qq;
        att(1'h0);
        chk(32'(r), 32'h5);
        att(1'h0);
        chk(32'(r), 32'h5);
        n = 0;
        while (r === 3'h5 && n < 100) begin
            repeat (3) @(posedge aclk);
            att(1'h1);
            n++;
        end
        chk(32'(r), 32'(exp));
    endtask

    // guard against a hung handshake
    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        results();
    end

    // q bits: read, multi, more, prefetch, special
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        rchk(REG_CTRL, 32'(CTRL_RESET));
        rchk(REG_TIMEOUT, 32'(TIMEOUT_RESET));
        rchk(REG_STATUS, 32'h0);
        rchk(REG_ATTEMPT, 32'h0);
        wr(REG_ATTEMPT, 32'h1);
        chk(32'(rr), 32'(RESP_SLVERR));
        txn(5'h08, 3'h7);
        dly = 2'h2;
        txn(5'h00, 3'h6);
        txn(5'h10, 3'h7);
        txn(5'h1a, 3'h6);
        dly = 2'h0;
        txn(5'h1e, 3'h7);
        // a full queue must not take the request in
        queue_full <= 1'h1;
        q = 5'h00;
        att(1'h0);
        repeat (30) @(posedge aclk);
        att(1'h1);
        chk(32'(r), 32'h5);
        queue_full <= 1'h0;
        txn(5'h00, 3'h6);
        mode = 2'h3;
        txn(5'h09, 3'h7);
        rchk(REG_STATUS, 32'h0);
        txn(5'h08, 3'h0);
        rchk(REG_STATUS, 32'h1);
        wr(REG_STATUS, 32'h7);
        mode = 2'h2;
        txn(5'h10, 3'h1);
        rchk(REG_STATUS, 32'h6);
        wr(REG_STATUS, 32'h7);
        mode = 2'h1;
        txn(5'h00, 3'h1);
        rchk(REG_ATTEMPT, 32'h4);
        wr(REG_STATUS, 32'h3);
        rchk(REG_STATUS, 32'h4);
        wr(REG_STATUS, 32'h7);
        mode = 2'h0;
        txn(5'h00, 3'h6);
        rchk(REG_ATTEMPT, 32'h0);
        // with starts disabled the request stays pending
        wr(REG_CTRL, 32'h0);
        att(1'h0);
        repeat (40) @(posedge aclk);
        chk(32'(frame_n_oe), 32'h0);
        wr(REG_CTRL, 32'h1);
        txn(5'h00, 3'h6);
        // a finished request not repeated in time is dropped
        wr(REG_TIMEOUT, 32'h14);
        att(1'h0);
        repeat (80) @(posedge aclk);
        att(1'h1);
        chk(32'(r), 32'h5);
        txn(5'h00, 3'h6);
        results();
    end
endmodule
